// File: inc/pfes_pkg.sv
// Constants and types for the processing logic error status register bank
package pfes_pkg;
  localparam logic [15:0] REG_BASE = 16'h0C10;
  localparam logic [9:0] IDX_AVAIL = 10'h000;
  localparam logic [9:0] IDX_FLAGS = 10'h001;
  localparam logic [7:0] AVAIL_NO = 8'h00;
  localparam logic [7:0] AVAIL_YES = 8'h01;
  localparam int BIT_NO_FW = 0;
  localparam int BIT_LOAD_FAIL = 1;
  localparam int BIT_RATE = 2;
  localparam int BIT_NO_TRIG = 3;
  localparam int BIT_NOT_READY = 4;
  localparam int BIT_PARAM = 5;
  localparam int ERR_BITS = 6;
  localparam logic [5:0] ERR_RST = 6'h00;
  localparam logic [31:0] RDATA_RST = 32'h00000000;
  localparam logic STICKY_RST = 1'b0;

  typedef struct packed {
    logic [5:0] err;
    logic [31:0] rdata;
    logic slverr;
  } pfes_state_t;

  typedef struct packed {
    logic q;
  } pfes_sticky_t;
endpackage

// File: rtl/pfes_sticky.sv
// Sticky summary flag, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module pfes_sticky
  import pfes_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  pfes_sticky_t state_reg;
  pfes_sticky_t state_next;

  always_comb begin
    state_next = state_reg;
    if (set) begin
      state_next.q = 1'b1;
    end else if (clr) begin
      state_next.q = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.q <= STICKY_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q = state_reg.q;
endmodule // pfes_sticky
`default_nettype wire

// File: rtl/pfes_top.sv
// APB register bank reporting processing logic error conditions
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Watch each error condition and set its flag once detected
// - Availability byte reads 0x01 when implemented, otherwise 0x00
// - Error byte sits at offset 0x0001 and ignores host writes
// - Error bits numbered from bit 0, one condition per bit
// - A bit reads 1 while its condition exists, else 0 (bit 1 also needs no-firmware clear)
// - Bit 0 no firmware, bit 1 load failed, bit 4 not ready
// - Bit 2 frame rate exceeded, bit 3 frame trigger missing
// - Bit 5 flags a bad, forbidden or conflicting parameter
// - Reading error byte clears not-ready and trigger summary bits unless their error bits are still set (set wins)
module pfes_top
  import pfes_pkg::*;
#(
  parameter bit IMPLEMENTED = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic no_firmware,
  input wire logic firmware_load_failed,
  input wire logic frame_rate_exceeded,
  input wire logic external_frame_trigger_missing,
  input wire logic logic_not_ready,
  input wire logic parameter_error,
  output logic not_ready_summary,
  output logic trigger_error_summary
);
  pfes_state_t state_reg;
  pfes_state_t state_next;
  logic [5:0] cond;
  logic [9:0] idx;
  logic aligned;
  logic setup;
  logic flags_read_done;
  logic [7:0] avail_code;
  logic [31:0] unused_wdata;

  assign unused_wdata = pwdata;
  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup = psel && !penable;
  assign avail_code = IMPLEMENTED ? AVAIL_YES : AVAIL_NO;

  always_comb begin
    cond = ERR_RST;
    cond[BIT_NO_FW] = no_firmware;
    cond[BIT_LOAD_FAIL] = firmware_load_failed && !no_firmware;
    cond[BIT_RATE] = frame_rate_exceeded;
    cond[BIT_NO_TRIG] = external_frame_trigger_missing;
    cond[BIT_NOT_READY] = logic_not_ready;
    cond[BIT_PARAM] = parameter_error;
  end

  always_comb begin
    state_next = state_reg;
    state_next.err = cond;
    if (setup) begin
      if (aligned && idx == IDX_AVAIL) begin
        state_next.slverr = 1'b0;
        state_next.rdata = pwrite ? state_reg.rdata : {24'h000000, avail_code};
      end else if (aligned && idx == IDX_FLAGS) begin
        state_next.slverr = 1'b0;
        // Writes are accepted and dropped
        state_next.rdata = pwrite ? state_reg.rdata :
          {24'h000000, 2'b00, state_reg.err};
      end else begin
        state_next.slverr = 1'b1;
        state_next.rdata = RDATA_RST;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.err <= ERR_RST;
      state_reg.rdata <= RDATA_RST;
      state_reg.slverr <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign pslverr = state_reg.slverr;
  assign pready = 1'b1;

  // Completed read of the error byte
  assign flags_read_done = psel && penable && !pwrite && aligned &&
    idx == IDX_FLAGS;

  // Summary flags for the general status word
  pfes_sticky u_not_ready_sum (
    .pclk(pclk),
    .presetn(presetn),
    .set(state_reg.err[BIT_NOT_READY]),
    .clr(flags_read_done),
    .q(not_ready_summary)
  );

  pfes_sticky u_trigger_sum (
    .pclk(pclk),
    .presetn(presetn),
    .set(state_reg.err[BIT_RATE] || state_reg.err[BIT_NO_TRIG]),
    .clr(flags_read_done),
    .q(trigger_error_summary)
  );

  // Bus and flag checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_avail_read;
    psel && !penable && !pwrite && aligned && idx == IDX_AVAIL;
  endsequence

  sequence s_flags_read;
    psel && !penable && !pwrite && aligned && idx == IDX_FLAGS
    ##1 psel && penable;
  endsequence

  sequence s_flags_write;
    psel && !penable && pwrite && aligned && idx == IDX_FLAGS;
  endsequence

  sequence s_bad_setup;
    psel && !penable && !(aligned && (idx == IDX_AVAIL || idx == IDX_FLAGS));
  endsequence

  flag_follow_a: assert property (
    $past(presetn) |-> state_reg.err == $past(cond))
    else $error("error flags do not follow conditions");

  avail_value_a: assert property (
    s_avail_read |=> prdata == {24'h000000, avail_code} && !pslverr)
    else $error("availability byte wrong");

  write_ignored_a: assert property (
    s_flags_write |=> !pslverr && prdata == $past(prdata))
    else $error("write to error byte had an effect");

  bit_order_a: assert property (
    s_flags_read |-> prdata[5:0] == $past(state_reg.err, 1))
    else $error("error byte bit order wrong");

  firmware_bits_a: assert property (
    (no_firmware ##1 1) |-> state_reg.err[BIT_NO_FW]
      && !state_reg.err[BIT_LOAD_FAIL])
    else $error("firmware bits wrong");

  ready_bit_a: assert property (
    logic_not_ready ##1 !logic_not_ready |=> !state_reg.err[BIT_NOT_READY])
    else $error("not ready bit stuck");

  trigger_bits_a: assert property (
    external_frame_trigger_missing && !frame_rate_exceeded
      |=> state_reg.err[BIT_NO_TRIG] && !state_reg.err[BIT_RATE])
    else $error("trigger bits wrong");

  param_bit_a: assert property (
    parameter_error |=> state_reg.err[BIT_PARAM] ##1 1)
    else $error("parameter bit missing");

  reserved_zero_a: assert property (
    s_flags_read |-> prdata[31:6] == 26'h0)
    else $error("reserved bits not zero");

  summary_clear_a: assert property (
    s_flags_read ##0 (!state_reg.err[BIT_NOT_READY]
      && !state_reg.err[BIT_RATE] && !state_reg.err[BIT_NO_TRIG])
      |=> !not_ready_summary && !trigger_error_summary)
    else $error("summary bits not cleared by read");

  summary_set_a: assert property (
    state_reg.err[BIT_NOT_READY] |=> not_ready_summary [*1])
    else $error("not ready summary not set");

  trigger_set_a: assert property (
    state_reg.err[BIT_RATE] || state_reg.err[BIT_NO_TRIG]
      |=> trigger_error_summary)
    else $error("trigger summary not set");

  summary_hold_a: assert property (
    not_ready_summary && !flags_read_done |=> not_ready_summary)
    else $error("not ready summary lost without read");

  trigger_hold_a: assert property (
    trigger_error_summary && !flags_read_done |=> trigger_error_summary)
    else $error("trigger summary lost without read");

  load_fail_bit_a: assert property (
    firmware_load_failed && !no_firmware |=> state_reg.err[BIT_LOAD_FAIL])
    else $error("load failure bit missing");

  not_ready_bit_a: assert property (
    logic_not_ready |=> state_reg.err[BIT_NOT_READY])
    else $error("not ready bit missing");

  rate_bit_a: assert property (
    frame_rate_exceeded |=> state_reg.err[BIT_RATE])
    else $error("frame rate bit missing");

  param_clear_a: assert property (
    !parameter_error |=> !state_reg.err[BIT_PARAM])
    else $error("parameter bit stuck");

  no_trig_clear_a: assert property (
    !external_frame_trigger_missing |=> !state_reg.err[BIT_NO_TRIG])
    else $error("trigger missing bit stuck");

  bad_address_a: assert property (
    s_bad_setup |=> pslverr && prdata == RDATA_RST)
    else $error("unmapped access not refused");
endmodule // pfes_top
`default_nettype wire

// File: verification/processing_fpga_error_status_bench.sv
// Self-checking bench for the processing logic error status bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("wrong value %s exp %h got %h", n, e, g); err_count++; end end
module processing_fpga_error_status_bench;
  import pfes_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, d, prdata_off, d_off;
  logic pready, pslverr, nrs, tes, e;
  logic [5:0] cond = 6'h00;
  int err_count = 0, compares = 0, cycles = 0;
  pfes_top pfes_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .no_firmware(cond[0]), .firmware_load_failed(cond[1]),
    .frame_rate_exceeded(cond[2]),
    .external_frame_trigger_missing(cond[3]),
    .logic_not_ready(cond[4]), .parameter_error(cond[5]),
    .not_ready_summary(nrs), .trigger_error_summary(tes));
  pfes_top #(.IMPLEMENTED(1'b0)) pfes_top_off_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata_off), .pready(),
    .pslverr(), .no_firmware(cond[0]), .firmware_load_failed(cond[1]),
    .frame_rate_exceeded(cond[2]),
    .external_frame_trigger_missing(cond[3]),
    .logic_not_ready(cond[4]), .parameter_error(cond[5]),
    .not_ready_summary(), .trigger_error_summary());
  initial begin
    forever #5 pclk = ~pclk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      test_done();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'hFFFFFFFF;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    d_off = prdata_off;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic set_cond(input logic [5:0] v);
    @(posedge pclk);
    cond <= v;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic t_avail();
    apb(1'b0, 12'h000);
    `CHK("avail", 32'h00000001, d)
    `CHK("avail err", 1'b0, e)
    `CHK("avail off", 32'h00000000, d_off)
  endtask
  task automatic t_bits();
    for (int i = 0; i < ERR_BITS; i++) begin
      set_cond(6'h01 << i);
      apb(1'b0, 12'h004);
      `CHK("flag bit", 32'h00000001 << i, d)
    end
    set_cond(6'h03);
    apb(1'b0, 12'h004);
    `CHK("masked load", 32'h00000001, d)
    set_cond(6'h00);
    apb(1'b0, 12'h004);
    `CHK("no flags", 32'h00000000, d)
  endtask
  task automatic t_write();
    set_cond(6'h3E);
    apb(1'b1, 12'h004);
    `CHK("wr err", 1'b0, e)
    apb(1'b1, 12'h000);
    apb(1'b0, 12'h004);
    `CHK("after wr", 32'h0000003E, d)
    apb(1'b0, 12'h000);
    `CHK("avail kept", 32'h00000001, d)
  endtask
  task automatic t_unmapped();
    apb(1'b0, 12'h008);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h00000000, d)
    apb(1'b0, 12'h005);
    `CHK("unaligned err", 1'b1, e)
  endtask
  task automatic t_summary();
    set_cond(6'h00);
    apb(1'b0, 12'h004);
    `CHK("te clr0", 1'b0, tes)
    set_cond(6'h10);
    set_cond(6'h00);
    `CHK("nr held", 1'b1, nrs)
    `CHK("te idle", 1'b0, tes)
    apb(1'b0, 12'h004);
    `CHK("nr clr", 1'b0, nrs)
    set_cond(6'h04);
    set_cond(6'h08);
    set_cond(6'h00);
    apb(1'b0, 12'h000);
    `CHK("te kept", 1'b1, tes)
    apb(1'b0, 12'h004);
    `CHK("te clr", 1'b0, tes)
  endtask
  task automatic t_reset();
    set_cond(6'h14);
    apb(1'b0, 12'h000);
    `CHK("nr set", 1'b1, nrs)
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    `CHK("mid rst data", 32'h00000000, prdata)
    `CHK("mid rst nr", 1'b0, nrs)
    `CHK("mid rst te", 1'b0, tes)
    @(posedge pclk);
    presetn <= 1'b1;
    set_cond(6'h00);
    `CHK("nr again", 1'b1, nrs)
    apb(1'b0, 12'h004);
    `CHK("flags gone", 32'h00000000, d)
    `CHK("te reclr", 1'b0, tes)
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    `CHK("rst nr", 1'b0, nrs)
    `CHK("rst data", 32'h00000000, prdata)
    `CHK("rst te", 1'b0, tes)
    `CHK("rst ready", 1'b1, pready)
    t_avail();
    t_bits();
    t_write();
    t_unmapped();
    t_summary();
    t_reset();
    test_done();
  end
endmodule // processing_fpga_error_status_bench
`default_nettype wire
